// ==== src/uhi_irq.sv ====
`timescale 1ns/1ps
module uhi_irq
    import uhi_pkg::*;
(
    input wire logic CLK_SYS, // system clock
    input wire logic RST_N, // async reset, active low
    input wire logic [15:0] ADDR, // register address
    input wire logic WR, // write strobe, one cycle
    input wire logic RD, // read strobe, one cycle
    input wire logic [15:0] WDATA, // write data
    output logic [15:0] RDATA, // read data, next cycle
    output logic RVALID, // read data valid pulse
    input wire logic VBUS_VALID, // vbus above threshold, pin
    input wire logic OTG_ID, // otg id pin
    input wire logic [1:0] PORTA_SE0, // port a se0 line state per engine, pin
    input wire logic [1:0] WAKE_EVT, // remote wakeup pulse per engine
    input wire logic [1:0] DONE_EVT, // transfer done pulse per engine
    output logic [1:0] IRQ // interrupt request per engine
);
    // three-stage synchronisers; value accepted once stages two and three agree
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] stable;
    logic [3:0] stable_d;
    logic [3:0] pin_edge;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {PORTA_SE0, OTG_ID, VBUS_VALID};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            stable <= 4'h0;
            stable_d <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sync2[i] == sync3[i]) begin
                    stable[i] <= sync3[i];
                end
            end
            stable_d <= stable;
        end
    end

    // edges are masked only in the first cycle after reset; a pin high out of reset still gives an edge
    logic prime;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prime <= 1'b0;
        end else begin
            prime <= 1'b1;
        end
    end

    assign pin_edge = prime ? (stable ^ stable_d) : 4'h0;

    // 12 mhz tick from the system clock by fractional accumulation
    logic [7:0] acc;
    logic tick;
    logic [7:0] acc_sum;
    assign acc_sum = acc + ACC_STEP;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            acc <= 8'h00;
            tick <= 1'b0;
        end else if (acc_sum >= ACC_MOD) begin
            acc <= acc_sum - ACC_MOD;
            tick <= 1'b1;
        end else begin
            acc <= acc_sum;
            tick <= 1'b0;
        end
    end

    logic [15:0] rd_word [NUM_ENGINES];
    logic [NUM_ENGINES-1:0] irq_req;

    for (genvar e = 0; e < NUM_ENGINES; e++) begin : g_eng
        localparam logic [15:0] MASK = (e == 0) ? MASK_ENG1 : MASK_ENG2;
        localparam logic [15:0] A_IEN = (e == 0) ? ADDR_IEN_1 : ADDR_IEN_2;
        localparam logic [15:0] A_FLAGS = (e == 0) ? ADDR_FLAGS_1 : ADDR_FLAGS_2;
        localparam logic [15:0] A_RELOAD = (e == 0) ? ADDR_RELOAD_1 : ADDR_RELOAD_2;

        logic [15:0] ien;
        logic [15:0] flags;
        logic [15:0] events;
        logic [15:0] clr;
        logic [RELOAD_WIDTH-1:0] reload;
        logic [RELOAD_WIDTH-1:0] count;
        logic expire;
        logic se0_now;

        assign se0_now = stable[2 + e];

        // enable fields, one register each; reserved bits stay zero
        logic en_vbus;
        logic en_id;
        logic en_frame;
        logic en_wake;
        logic en_conn;
        logic en_done;
        logic ien_wr;
        assign ien_wr = WR && (ADDR == A_IEN);

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                en_vbus <= IEN_RESET[BIT_VBUS];
            end else if (ien_wr) begin
                en_vbus <= WDATA[BIT_VBUS] & MASK[BIT_VBUS];
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                en_id <= IEN_RESET[BIT_ID];
            end else if (ien_wr) begin
                en_id <= WDATA[BIT_ID] & MASK[BIT_ID];
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                en_frame <= IEN_RESET[BIT_FRAME];
            end else if (ien_wr) begin
                en_frame <= WDATA[BIT_FRAME];
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                en_wake <= IEN_RESET[BIT_WAKE];
            end else if (ien_wr) begin
                en_wake <= WDATA[BIT_WAKE];
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                en_conn <= IEN_RESET[BIT_CONN];
            end else if (ien_wr) begin
                en_conn <= WDATA[BIT_CONN];
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                en_done <= IEN_RESET[BIT_DONE];
            end else if (ien_wr) begin
                en_done <= WDATA[BIT_DONE];
            end
        end

        always_comb begin
            ien = 16'h0000;
            ien[BIT_VBUS] = en_vbus;
            ien[BIT_ID] = en_id;
            ien[BIT_FRAME] = en_frame;
            ien[BIT_WAKE] = en_wake;
            ien[BIT_CONN] = en_conn;
            ien[BIT_DONE] = en_done;
        end

        // frame reload register and down counter
        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                reload <= RELOAD_RESET;
            end else if (WR && ADDR == A_RELOAD) begin
                reload <= WDATA[RELOAD_WIDTH-1:0];
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                count <= RELOAD_RESET;
                expire <= 1'b0;
            end else if (tick) begin
                if (count == '0) begin
                    count <= reload;
                    expire <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                    expire <= 1'b0;
                end
            end else begin
                expire <= 1'b0;
            end
        end

        // event sources for the flags
        always_comb begin
            events = 16'h0000;
            events[BIT_VBUS] = pin_edge[0];
            events[BIT_ID] = pin_edge[1];
            events[BIT_FRAME] = expire;
            events[BIT_WAKE] = WAKE_EVT[e];
            events[BIT_CONN] = pin_edge[2 + e];
            events[BIT_DONE] = DONE_EVT[e];
            events = events & MASK;
        end

        // write one clears; an event in the clearing cycle wins
        logic fl_vbus;
        logic fl_id;
        logic fl_frame;
        logic fl_wake;
        logic fl_conn;
        logic fl_done;
        assign clr = (WR && ADDR == A_FLAGS) ? WDATA : 16'h0000;

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                fl_vbus <= FLAGS_RESET[BIT_VBUS];
            end else if (events[BIT_VBUS]) begin
                fl_vbus <= 1'b1;
            end else if (clr[BIT_VBUS]) begin
                fl_vbus <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                fl_id <= FLAGS_RESET[BIT_ID];
            end else if (events[BIT_ID]) begin
                fl_id <= 1'b1;
            end else if (clr[BIT_ID]) begin
                fl_id <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                fl_frame <= FLAGS_RESET[BIT_FRAME];
            end else if (events[BIT_FRAME]) begin
                fl_frame <= 1'b1;
            end else if (clr[BIT_FRAME]) begin
                fl_frame <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                fl_wake <= FLAGS_RESET[BIT_WAKE];
            end else if (events[BIT_WAKE]) begin
                fl_wake <= 1'b1;
            end else if (clr[BIT_WAKE]) begin
                fl_wake <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                fl_conn <= FLAGS_RESET[BIT_CONN];
            end else if (events[BIT_CONN]) begin
                fl_conn <= 1'b1;
            end else if (clr[BIT_CONN]) begin
                fl_conn <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                fl_done <= FLAGS_RESET[BIT_DONE];
            end else if (events[BIT_DONE]) begin
                fl_done <= 1'b1;
            end else if (clr[BIT_DONE]) begin
                fl_done <= 1'b0;
            end
        end

        always_comb begin
            flags = 16'h0000;
            flags[BIT_VBUS] = fl_vbus;
            flags[BIT_ID] = fl_id;
            flags[BIT_FRAME] = fl_frame;
            flags[BIT_WAKE] = fl_wake;
            flags[BIT_CONN] = fl_conn;
            flags[BIT_DONE] = fl_done;
        end

        assign irq_req[e] = |(flags & ien);

        always_comb begin
            rd_word[e] = 16'h0000;
            if (ADDR == A_IEN) begin
                rd_word[e] = ien;
            end else if (ADDR == A_FLAGS) begin
                rd_word[e] = flags;
                rd_word[e][BIT_SE0] = se0_now;
            end else if (ADDR == A_RELOAD) begin
                rd_word[e] = {{(16 - RELOAD_WIDTH){1'b0}}, reload};
            end
        end
    end

    // registered read answer; unmapped addresses read zero
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
            RVALID <= 1'b0;
        end else begin
            RVALID <= RD;
            if (RD) begin
                RDATA <= rd_word[0] | rd_word[1];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 2'b00;
        end else begin
            IRQ <= irq_req;
        end
    end
endmodule : uhi_irq

// ==== src/uhi_pkg.sv ====
package uhi_pkg;
    localparam int NUM_ENGINES = 2;
    // register offsets on the parallel host port, per engine
    localparam logic [15:0] ADDR_IEN_1 = 16'hc08c;
    localparam logic [15:0] ADDR_FLAGS_1 = 16'hc090;
    localparam logic [15:0] ADDR_RELOAD_1 = 16'hc092;
    localparam logic [15:0] ADDR_IEN_2 = 16'hc0ac;
    localparam logic [15:0] ADDR_FLAGS_2 = 16'hc0b0;
    localparam logic [15:0] ADDR_RELOAD_2 = 16'hc0b2;
    // bit positions shared by enable and status registers; BIT_SE0 is in the status register only
    localparam int BIT_VBUS = 15;
    localparam int BIT_ID = 14;
    localparam int BIT_FRAME = 9;
    localparam int BIT_WAKE = 6;
    localparam int BIT_CONN = 4;
    localparam int BIT_SE0 = 2;
    localparam int BIT_DONE = 0;
    // implemented bits: engine one has the otg bits, engine two does not
    localparam logic [15:0] MASK_ENG1 = 16'hc251;
    localparam logic [15:0] MASK_ENG2 = 16'h0251;
    localparam logic [15:0] IEN_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    // frame timer
    localparam int RELOAD_WIDTH = 14;
    localparam logic [13:0] RELOAD_RESET = 14'h2ee0;
    localparam int SYS_CLK_KHZ = 125000;
    localparam int TICK_KHZ = 12000;
    localparam logic [7:0] ACC_STEP = 8'(TICK_KHZ / 1000);
    localparam logic [7:0] ACC_MOD = 8'(SYS_CLK_KHZ / 1000);
endpackage : uhi_pkg

// ==== bench/uhi_irq_monitor.sv ====
`timescale 1ns/1ps
module uhi_irq_monitor
    import uhi_pkg::*;
(
    input wire logic CLK_SYS, // system clock
    input wire logic RST_N, // reset, active low
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    input wire logic RVALID, // read answer
    input wire logic VBUS_VALID, // vbus pin
    input wire logic OTG_ID, // id pin
    input wire logic [15:0] ADDR, // address
    input wire logic [15:0] WDATA, // write data
    input wire logic [15:0] RDATA, // read data
    input wire logic [1:0] PORTA_SE0, // se0 per engine
    input wire logic [1:0] WAKE_EVT, // wakeup per engine
    input wire logic [1:0] DONE_EVT, // done per engine
    input wire logic [1:0] IRQ // request per engine
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [15:0] en1;
    always_ff @(posedge CLK_SYS or negedge RST_N)
        en1 <= !RST_N ? IEN_RESET : (WR && ADDR == ADDR_IEN_1) ? (WDATA & MASK_ENG1) : en1;
    sequence done_quiet_s;
        DONE_EVT[0] && en1[BIT_DONE] && !WR ##1 !WR;
    endsequence
    rd_answer_a: assert property (RD |=> RVALID) else $error("read unanswered");
    rd_spare_a: assert property (!RD |=> !RVALID) else $error("stray read valid");
    done_irq_a: assert property (done_quiet_s |=> IRQ[0]) else $error("no done irq");
    mask_irq_a: assert property (en1 == 16'h0 && $past(en1) == 16'h0 |-> !IRQ[0])
        else $error("irq while masked");
    se0_live_a: assert property (($stable(PORTA_SE0[0]) [*8] ##0 (RD && ADDR == ADDR_FLAGS_1))
        |=> RDATA[BIT_SE0] == $past(PORTA_SE0[0])) else $error("se0 status wrong");
    res_zero_a: assert property (RVALID && $past(ADDR) == ADDR_IEN_2 |-> (RDATA & ~MASK_ENG2) == 0)
        else $error("reserved bit set");
    unmap_zero_a: assert property (RVALID && ($past(ADDR) & 16'hff00) != 16'hc000 |-> RDATA == 0)
        else $error("unmapped read");
    reload_w_a: assert property (RVALID && $past(ADDR) == ADDR_RELOAD_1 |-> RDATA[15:14] == 2'h0)
        else $error("reload too wide");
endmodule : uhi_irq_monitor
bind uhi_irq uhi_irq_monitor mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WR(WR), .RD(RD),
    .RVALID(RVALID), .VBUS_VALID(VBUS_VALID), .OTG_ID(OTG_ID), .ADDR(ADDR), .WDATA(WDATA),
    .RDATA(RDATA), .PORTA_SE0(PORTA_SE0), .WAKE_EVT(WAKE_EVT), .DONE_EVT(DONE_EVT), .IRQ(IRQ));

// ==== bench/uhi_usb_peer.sv ====
`timescale 1ns/1ps
module uhi_usb_peer (
    input wire logic CLK_SYS, // clock
    output logic VBUS_VALID = 1'b0, // vbus level
    output logic OTG_ID = 1'b0, // id pin
    output logic [1:0] PORTA_SE0 = 2'h0, // line state
    output logic [1:0] WAKE_EVT = 2'h0, // wakeup pulse
    output logic [1:0] DONE_EVT = 2'h0 // done pulse
);
    // pins hold their level, events last one cycle
    task automatic act(input logic v, i, input logic [1:0] s, w, d);
        @(posedge CLK_SYS) #1;
        VBUS_VALID = v;
        OTG_ID = i;
        PORTA_SE0 = s;
        WAKE_EVT = w;
        DONE_EVT = d;
        @(posedge CLK_SYS) #1;
        WAKE_EVT = 2'h0;
        DONE_EVT = 2'h0;
    endtask : act
endmodule : uhi_usb_peer

// ==== bench/uhi_irq_test.sv ====
`timescale 1ns/1ps
module uhi_irq_test import uhi_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rvalid, vbus, id;
    logic [15:0] addr = 16'h0, wdata = 16'h0, rdata;
    logic [1:0] se0, wake, done, irq;
    int n_mismatch = 0;
    int n_compared = 0;
    uhi_irq dut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata),
        .RDATA(rdata), .RVALID(rvalid), .VBUS_VALID(vbus), .OTG_ID(id), .PORTA_SE0(se0),
        .WAKE_EVT(wake), .DONE_EVT(done), .IRQ(irq));
    uhi_usb_peer peer (.CLK_SYS(clk), .VBUS_VALID(vbus), .OTG_ID(id), .PORTA_SE0(se0),
        .WAKE_EVT(wake), .DONE_EVT(done));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // write when w is high, else read and compare with d
    task automatic acc(input logic w, input logic [15:0] a, d);
        @(posedge clk) #1;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(posedge clk) #1;
        wr = 1'b0;
        rd = 1'b0;
        if (!w) chk(rdata, d);
    endtask : acc
    task automatic t_regs;
        acc(1'b0, ADDR_IEN_1, 16'h0000);
        acc(1'b0, ADDR_IEN_2, 16'h0000);
        acc(1'b0, ADDR_RELOAD_2, 16'h2ee0);
        acc(1'b1, ADDR_IEN_1, 16'hc251);
        acc(1'b0, ADDR_IEN_1, 16'hc251);
        acc(1'b1, ADDR_RELOAD_1, 16'h1234);
        acc(1'b0, ADDR_RELOAD_1, 16'h1234);
        acc(1'b0, 16'h1234, 16'h0000);
        $display("regs done");
    endtask : t_regs
    task automatic t_done;
        acc(1'b1, ADDR_IEN_1, 16'h0001);
        peer.act(1'b0, 1'b0, 2'b00, 2'b00, 2'b01);
        @(posedge clk) #1;
        chk({14'h0, irq}, 16'h0001);
        acc(1'b1, ADDR_FLAGS_1, 16'h0000);
        acc(1'b0, ADDR_FLAGS_1, 16'h0001);
        acc(1'b1, ADDR_FLAGS_1, 16'h0001);
        acc(1'b0, ADDR_FLAGS_1, 16'h0000);
        peer.act(1'b0, 1'b0, 2'b00, 2'b01, 2'b10);
        acc(1'b0, ADDR_FLAGS_2, 16'h0001);
        acc(1'b0, ADDR_FLAGS_1, 16'h0040);
        chk({14'h0, irq}, 16'h0000);
        $display("done done");
    endtask : t_done
    task automatic t_pins;
        acc(1'b1, ADDR_IEN_1, 16'hc000);
        peer.act(1'b1, 1'b1, 2'b01, 2'b00, 2'b00);
        repeat (8) @(posedge clk);
        acc(1'b0, ADDR_FLAGS_1, 16'hc054);
        acc(1'b0, ADDR_FLAGS_2, 16'h0001);
        chk({14'h0, irq}, 16'h0001);
        acc(1'b1, ADDR_IEN_2, 16'h0001);
        @(posedge clk) #1;
        chk({14'h0, irq}, 16'h0003);
        acc(1'b1, ADDR_FLAGS_1, 16'hc050);
        peer.act(1'b0, 1'b1, 2'b00, 2'b00, 2'b00);
        repeat (8) @(posedge clk);
        acc(1'b0, ADDR_FLAGS_1, 16'h8010);
        $display("pins done");
    endtask : t_pins
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clk);
        t_regs;
        t_done;
        t_pins;
        results;
    end
endmodule : uhi_irq_test
